// ===== shared/ppgp_regs.svh
// constants for the push-pull gate phaser: offsets, fields, timing
// assumes a 250 MHz pclk and 32-bit apb data
//
// How it works
// R1 - halve oscillator into two complementary phases
// R2 - both gates low for dead time first
// R3 - floating enable pin reads as disabled
// R4 - disabled or under 1.7 V tri-states drains
// R5 - start oscillator and switching above 2.25 V
// R6 - soft-start ramp on power-up and enable
// R7 - external clock rising edge toggles phase
// R8 - lost external clock reverts to internal
// R9 - internal clock is spread-spectrum modulated
// R10 - no spread while external clock drives
// R11 - system supplies common clock for sync
// R12 - fail-safe revert after 10 to 25 us
// R13 - dead time and timeout counted in cycles
// R14 - external valid after edge, resumes on edges
`ifndef PPGP_REGS_SVH
`define PPGP_REGS_SVH

// ****************************************
// register map
// ****************************************
`define PPGP_CTRL_OFF 12'h000
`define PPGP_STAT_OFF 12'h004
`define PPGP_CTRL_RST 2'h3
`define PPGP_CTRL_EXT_BIT 0
`define PPGP_CTRL_SPREAD_BIT 1

// ****************************************
// timing
// ****************************************
`define PPGP_CLK_KHZ 250000
`define PPGP_DEAD_NS 115
`define PPGP_DEAD_CYC ((`PPGP_DEAD_NS * `PPGP_CLK_KHZ + 999999) / 1000000)
`define PPGP_FAILSAFE_US 12
`define PPGP_FAILSAFE_CYC ((`PPGP_FAILSAFE_US * `PPGP_CLK_KHZ) / 1000)
`define PPGP_OSC_KHZ 320
`define PPGP_OSC_HALF_CYC (`PPGP_CLK_KHZ / `PPGP_OSC_KHZ)
`define PPGP_SPREAD_SPAN 64
`define PPGP_SS_US 4250
`define PPGP_SS_STEP_CYC ((`PPGP_SS_US * (`PPGP_CLK_KHZ / 1000)) / 256)

`endif

// ===== shared/ppgp_pkg.sv
// types shared by the gate phaser files
// assumes ppgp_regs.svh supplies the numeric constants
`default_nettype none
package ppgp_pkg;

   // drive bundle toward the two power switches
   typedef struct packed {
      logic gate_a;
      logic gate_b;
      logic oe_a;
      logic oe_b;
      logic [7:0] level;
   } ppgp_drive_t;

   // switching source selection
   typedef enum logic [1:0] {
      SRC_OFF = 2'h0,
      SRC_INT = 2'h1,
      SRC_EXT = 2'h2
   } ppgp_src_t;

endpackage : ppgp_pkg
`default_nettype wire

// ===== rtl/ppgp_phase_gen.sv
// divide-by-two phase stage with break-before-make dead time
// assumes toggle is a one-cycle pulse on pclk
`timescale 1ns/100ps
`default_nettype none
`include "ppgp_regs.svh"

module ppgp_phase_gen
   import ppgp_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic run,
   input wire logic toggle,
   // gates and phase
   output logic gate_a_q,
   output logic gate_b_q,
   output logic phase_q
);

   // dead-time counter, wide enough for the cycle count
   logic [7:0] dead_q;

   // ****************************************
   // phase divider
   // ****************************************
   // R1 halve the clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase_q <= 1'b0;
      else if (!run)
         phase_q <= 1'b0;
      else if (toggle)
         phase_q <= ~phase_q;
   end

   // ****************************************
   // dead time and gates
   // ****************************************
   // R2 break before make
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dead_q <= 8'h00;
         gate_a_q <= 1'b0;
         gate_b_q <= 1'b0;
      end
      else if (!run || toggle)
      begin
         // any edge first drops both gates, reload the gap
         dead_q <= 8'(`PPGP_DEAD_CYC);
         gate_a_q <= 1'b0;
         gate_b_q <= 1'b0;
      end
      else if (dead_q != 8'h00)
         dead_q <= dead_q - 8'h01;
      else
      begin
         // R1 complementary gates
         gate_a_q <= ~phase_q;
         gate_b_q <= phase_q;
      end
   end

endmodule : ppgp_phase_gen
`default_nettype wire

// ===== rtl/ppgp_top.sv
// push-pull gate phaser: source select, spread, fail-safe, soft-start
// assumes asynchronous pins (enable, clock, supply flags) and an apb master
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ppgp_regs.svh"

module ppgp_top
   import ppgp_pkg::*;
#(
   // soft-start cycles per drive step, shorten in simulation
   parameter int unsigned SS_STEP_CYC = `PPGP_SS_STEP_CYC
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // device pins, all asynchronous
   input wire logic enable_pin,
   input wire logic ext_clock_pin,
   input wire logic supply_above_2v25,
   input wire logic supply_above_1v7,
   // switch drive
   output ppgp_drive_t drive
);

   // ****************************************
   // declarations
   // ****************************************
   // synchroniser stages, first ones read only by second
   logic en_s1_q, en_s2_q;
   logic ck_s1_q, ck_s2_q, ck_s3_q;
   logic hi_s1_q, hi_s2_q;
   logic lo_s1_q, lo_s2_q;
   // supply lockout with hysteresis
   logic supply_ok_q;
   // running state and its previous value
   logic active;
   logic active_prev_q;
   // software control bits
   logic [1:0] ctrl_q;
   // external clock tracking
   logic ext_edge;
   logic [11:0] fs_cnt_q;
   logic ext_valid_q;
   // internal oscillator
   logic [11:0] osc_cnt_q;
   logic [11:0] osc_half;
   logic osc_tick;
   logic [5:0] tri_q;
   logic tri_up_q;
   // source selection
   ppgp_src_t src_q;
   logic toggle;
   // soft-start
   logic [31:0] ss_cnt_q;
   logic [7:0] level_q;
   // phase stage results
   logic gate_a, gate_b, phase;
   // apb helpers
   logic apb_acc;
   logic [31:0] rd_d;
   logic err_d;

   // ****************************************
   // input synchronisers
   // ****************************************
   // two flops on every pin before logic sees it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_s1_q <= 1'b0;
         en_s2_q <= 1'b0;
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_s3_q <= 1'b0;
         hi_s1_q <= 1'b0;
         hi_s2_q <= 1'b0;
         lo_s1_q <= 1'b0;
         lo_s2_q <= 1'b0;
      end
      else
      begin
         en_s1_q <= enable_pin;
         en_s2_q <= en_s1_q;
         ck_s1_q <= ext_clock_pin;
         ck_s2_q <= ck_s1_q;
         // third stage only for edge detection
         ck_s3_q <= ck_s2_q;
         hi_s1_q <= supply_above_2v25;
         hi_s2_q <= hi_s1_q;
         lo_s1_q <= supply_above_1v7;
         lo_s2_q <= lo_s1_q;
      end
   end

   // ****************************************
   // supply lockout
   // ****************************************
   // R5 start at 2.25 V
   // R4 drop below 1.7 V
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         supply_ok_q <= 1'b0;
      else if (!lo_s2_q)
         supply_ok_q <= 1'b0;
      else if (hi_s2_q)
         supply_ok_q <= 1'b1;
   end

   // R3 pulled-down pin
   // the pin's pull-down resistor sits outside; a floating pin
   // reads low here, so only a driven high enables switching
   assign active = en_s2_q && supply_ok_q;

   // previous running state, seeds the soft-start restart
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         active_prev_q <= 1'b0;
      else
         active_prev_q <= active;
   end

   // ****************************************
   // external clock fail-safe
   // ****************************************
   // rising edge of the synchronised external clock
   assign ext_edge = ck_s2_q && !ck_s3_q;

   // R13 timeout in cycles
   // R12 revert window
   // counter saturates at the timeout; an edge restarts it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fs_cnt_q <= 12'h000;
      else if (ext_edge)
         fs_cnt_q <= 12'h000;
      else if (fs_cnt_q != 12'(`PPGP_FAILSAFE_CYC))
         fs_cnt_q <= fs_cnt_q + 12'h001;
   end

   // R14 valid after edge
   // R8 revert on timeout
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ext_valid_q <= 1'b0;
      else if (ext_edge)
         ext_valid_q <= 1'b1;
      else if (fs_cnt_q == 12'(`PPGP_FAILSAFE_CYC))
         ext_valid_q <= 1'b0;
   end

   // ****************************************
   // source selection
   // ****************************************
   // R11 external sync clock
   // external mode needs software permission and a live clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         src_q <= SRC_OFF;
      else if (!active)
         src_q <= SRC_OFF;
      else if (ext_valid_q && ctrl_q[`PPGP_CTRL_EXT_BIT])
         src_q <= SRC_EXT;
      else
         src_q <= SRC_INT;
   end

   // ****************************************
   // internal oscillator with spread spectrum
   // ****************************************
   // R9 modulate period
   // R10 no spread on external
   // triangle offset of -32..+31 cycles on the half period
   assign osc_half = (ctrl_q[`PPGP_CTRL_SPREAD_BIT] && src_q == SRC_INT)
      ? 12'(`PPGP_OSC_HALF_CYC - (`PPGP_SPREAD_SPAN / 2)) + {6'h00, tri_q}
      : 12'(`PPGP_OSC_HALF_CYC);

   // tick at the end of each half period
   assign osc_tick = (osc_cnt_q >= osc_half - 12'h001);

   // R5 oscillator runs
   // halted while disabled so it draws nothing and restarts cleanly
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         osc_cnt_q <= 12'h000;
      else if (!active || osc_tick)
         osc_cnt_q <= 12'h000;
      else
         osc_cnt_q <= osc_cnt_q + 12'h001;
   end

   // triangle sweep, one step per oscillator half period
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tri_q <= 6'h00;
         tri_up_q <= 1'b1;
      end
      else if (active && osc_tick)
      begin
         // turn around at both ends so the sweep never wraps
         if (tri_up_q && tri_q == 6'h3E)
            tri_up_q <= 1'b0;
         else if (!tri_up_q && tri_q == 6'h01)
            tri_up_q <= 1'b1;
         if (tri_up_q)
            tri_q <= tri_q + 6'h01;
         else
            tri_q <= tri_q - 6'h01;
      end
   end

   // R7 external edge toggles
   // R1 selected source
   always_comb
   begin
      unique case (src_q)
         SRC_EXT: toggle = ext_edge;
         SRC_INT: toggle = osc_tick;
         default: toggle = 1'b0;
      endcase
   end

   // ****************************************
   // phase and dead time
   // ****************************************
   // R2 dead time stage
   ppgp_phase_gen u_phase (
      .pclk(pclk),
      .presetn(presetn),
      .run(src_q != SRC_OFF),
      .toggle(toggle),
      .gate_a_q(gate_a),
      .gate_b_q(gate_b),
      .phase_q(phase)
   );

   // ****************************************
   // soft-start
   // ****************************************
   // R6 ramp gate drive
   // restarts from zero on every rise of the running state, which
   // covers both power-up and a low-to-high enable edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ss_cnt_q <= 32'h0000_0000;
         level_q <= 8'h00;
      end
      else if (!active || !active_prev_q)
      begin
         ss_cnt_q <= 32'h0000_0000;
         level_q <= 8'h00;
      end
      else if (level_q != 8'hFF)
      begin
         if (ss_cnt_q >= SS_STEP_CYC - 1)
         begin
            ss_cnt_q <= 32'h0000_0000;
            level_q <= level_q + 8'h01;
         end
         else
            ss_cnt_q <= ss_cnt_q + 32'h0000_0001;
      end
   end

   // ****************************************
   // output register
   // ****************************************
   // R4 tri-state drains
   // enables fall with the running state; gates stay low meanwhile
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         drive <= '0;
      else
      begin
         drive.gate_a <= gate_a && active;
         drive.gate_b <= gate_b && active;
         drive.oe_a <= active;
         drive.oe_b <= active;
         drive.level <= level_q;
      end
   end

   // ****************************************
   // apb slave
   // ****************************************
   // access phase cycle that completes this edge
   assign apb_acc = psel && penable && pready;

   // read mux and decode error, unmapped reads return zero
   always_comb
   begin
      rd_d = 32'h0000_0000;
      err_d = 1'b0;
      unique case (paddr)
         `PPGP_CTRL_OFF: rd_d = {30'h0000_0000, ctrl_q};
         `PPGP_STAT_OFF:
            rd_d = {16'h0000, level_q, 3'h0, phase,
                    ext_valid_q, src_q == SRC_EXT, supply_ok_q, active};
         default: err_d = 1'b1;
      endcase
   end

   // one wait state: ready rises in the second access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && penable && !pready;
         prdata <= (psel && penable && !pready && !pwrite)
            ? rd_d : 32'h0000_0000;
         pslverr <= psel && penable && !pready && err_d;
      end
   end

   // control register, written only at the completing edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_q <= `PPGP_CTRL_RST;
      else if (apb_acc && pwrite && paddr == `PPGP_CTRL_OFF)
         ctrl_q <= pwdata[1:0];
   end

endmodule : ppgp_top
`default_nettype wire

// ===== bench/ppgp_top_asserts.sv
// port checker for the gate phaser top
// assumes it is bound into every ppgp_top instance
`timescale 1ns/100ps
`default_nettype none
module ppgp_top_asserts
   import ppgp_pkg::*;
(
   // clock, reset and apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // pins and switch drive
   input wire logic enable_pin,
   input wire logic supply_above_1v7,
   input wire ppgp_drive_t drive
);
   // ******************
   // helper, properties
   // ******************
   // cycles with both gates off, saturating so it never wraps
   logic [7:0] low_q;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // restart on any turn-on so each gap is measured alone
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         low_q <= 8'h00;
      else if (drive.gate_a || drive.gate_b)
         low_q <= 8'h00;
      else if (low_q != 8'hFF)
         low_q <= low_q + 8'h01;
   end
   property p_excl;
      !(drive.gate_a && drive.gate_b);
   endproperty
   a_excl: assert property (p_excl) else $error("gates overlap");
   property p_dead;
      $rose(drive.gate_a) || $rose(drive.gate_b) |-> low_q >= 8'h1D;
   endproperty
   a_dead: assert property (p_dead) else $error("short dead time");
   property p_alt;
      $fell(drive.gate_a) && enable_pin && supply_above_1v7
         |-> ##[29:30] drive.gate_b;
   endproperty
   a_alt: assert property (p_alt) else $error("no b phase");
   property p_off;
      $fell(enable_pin) || $fell(supply_above_1v7)
         |-> ##[1:8] drive == 12'h000;
   endproperty
   a_off: assert property (p_off) else $error("drains not released");
   property p_oe;
      drive.oe_a == drive.oe_b;
   endproperty
   a_oe: assert property (p_oe) else $error("drain enables differ");
   property p_ramp;
      drive.oe_a && $past(drive.oe_a) && enable_pin && supply_above_1v7
         |-> drive.level - $past(drive.level) <= 8'h01;
   endproperty
   a_ramp: assert property (p_ramp) else $error("drive level jump");
   // apb one wait state
   property p_wait;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_wait: assert property (p_wait) else $error("bad apb answer");
   // apb unmapped refused
   property p_err;
      pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004);
   endproperty
   a_err: assert property (p_err) else $error("bad slave error");
   c_b: cover property ($rose(drive.gate_b));
   c_err: cover property (pready && pslverr);
   c_on: cover property ($rose(drive.oe_a));
endmodule : ppgp_top_asserts
bind ppgp_top ppgp_top_asserts u_chk (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .paddr(paddr),
   .pready(pready),
   .pslverr(pslverr),
   .enable_pin(enable_pin),
   .supply_above_1v7(supply_above_1v7),
   .drive(drive)
);
`default_nettype wire

// ===== bench/ppgp_xfmr_model.sv
// model of the two switches and the shared sync clock
// assumes drive from ppgp_top and a run request from the bench
`timescale 1ns/100ps
`default_nettype none
module ppgp_xfmr_model
   import ppgp_pkg::*;
#(
   // sync clock half period in pclk cycles
   parameter int HALF = 250
)
(
   // clock and control
   input wire logic pclk,
   input wire logic run,
   // drive in, sync clock and core flux out
   input wire ppgp_drive_t drive,
   output var logic ext_clock_pin,
   output var int flux
);
   // *********
   // behaviour
   // *********
   int cnt = 0;
   initial
      flux = 0;
   initial
      ext_clock_pin = 1'b0;
   // common sync clock, parked low while stopped
   always @(posedge pclk)
   begin
      cnt <= (!run || cnt == HALF - 1) ? 0 : cnt + 1;
      ext_clock_pin <= run && (ext_clock_pin ^ (cnt == HALF - 1));
   end
   // volt-seconds: a pushes the core, b pulls it back
   always @(posedge pclk)
      flux <= flux + int'(drive.gate_a) - int'(drive.gate_b);
endmodule : ppgp_xfmr_model
`default_nettype wire

// ===== bench/push_pull_gate_phaser_tb.sv
// self-checking bench for the push-pull gate phaser
// assumes ppgp_top, the switch model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "ppgp_regs.svh"
module push_pull_gate_phaser_tb
   import ppgp_pkg::*;
;
   // apb, reset; a released enable drops to its pull-down
   logic pclk, pready, pslverr, err, ext;
   logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic en_drv = 1'b1, v2 = 1'b0, v1 = 1'b0, run = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   tri0 enable_pin;
   ppgp_drive_t drive;
   int miscompares = 0, checks = 0, flux, p[4];
   assign enable_pin = en_drv;
   ppgp_top #(.SS_STEP_CYC(4)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .enable_pin(enable_pin), .ext_clock_pin(ext),
      .supply_above_2v25(v2), .supply_above_1v7(v1), .drive(drive));
   ppgp_xfmr_model #(.HALF(250)) u_xfmr (.pclk(pclk), .run(run),
      .drive(drive), .ext_clock_pin(ext), .flux(flux));
   task report_and_stop;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk
   // one transfer; request held until pready is seen high at a rising edge,
   // answer taken and request released at that same edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no cycle count assumed; only the watchdog ends a stuck wait
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // gate a rise to rise, counted on the quiet edge
   task gap(output int n);
      n = 0;
      while (drive.gate_a === 1'b1 && n < 9000)
         @(negedge pclk) n++;
      while (drive.gate_a !== 1'b1 && n < 9000)
         @(negedge pclk) n++;
   endtask : gap
   task t_regs;
      apb(1'b0, `PPGP_CTRL_OFF, 32'h0);
      chk(rd, 32'h3, "ctrl reset");
      apb(1'b1, `PPGP_CTRL_OFF, 32'hFFFFFFFC);
      apb(1'b0, `PPGP_CTRL_OFF, 32'h0);
      chk(rd, 32'h0, "ctrl write");
      apb(1'b1, `PPGP_CTRL_OFF, 32'h3);
      apb(1'b0, 12'h008, 32'h0);
      chk(err, 1'b1, "unmapped refused");
      chk(rd, 32'h0, "unmapped reads zero");
      $display("t_regs done");
   endtask : t_regs
   task t_float;
      v1 <= 1'b1;
      repeat (50) @(negedge pclk);
      chk(drive, 12'h000, "below start level");
      @(posedge pclk);
      en_drv <= 1'bz;
      v2 <= 1'b1;
      repeat (50) @(negedge pclk);
      chk(drive, 12'h000, "floating enable");
      $display("t_float done");
   endtask : t_float
   task t_start;
      @(posedge pclk);
      en_drv <= 1'b1;
      repeat (10) @(negedge pclk);
      chk(drive.oe_a && drive.level < 8'h10, 1'b1, "soft start");
      repeat (1100) @(negedge pclk);
      chk(drive.level, 8'hFF, "full drive");
      gap(p[0]);
      for (int k = 0; k < 4; k++)
      begin
         gap(p[k]);
         chk(p[k] >= 1496 && p[k] <= 1626, 1'b1, "internal rate");
      end
      chk(p[0] == p[1] && p[1] == p[2], 1'b0, "no spread");
      chk(flux > -900 && flux < 900, 1'b1, "flux balance");
      $display("t_start done");
   endtask : t_start
   task t_ext;
      @(posedge pclk);
      run <= 1'b1;
      repeat (3000) @(negedge pclk);
      gap(p[0]);
      gap(p[0]);
      gap(p[1]);
      chk(p[0], 1000, "sync rate");
      chk(p[1], 1000, "sync steady");
      apb(1'b0, `PPGP_STAT_OFF, 32'h0);
      chk(rd & 32'h4, 32'h4, "external used");
      $display("t_ext done");
   endtask : t_ext
   task t_fail;
      @(posedge pclk);
      run <= 1'b0;
      repeat (1800) @(negedge pclk);
      apb(1'b0, `PPGP_STAT_OFF, 32'h0);
      chk(rd & 32'h4, 32'h4, "early revert");
      repeat (1500) @(negedge pclk);
      apb(1'b0, `PPGP_STAT_OFF, 32'h0);
      chk(rd & 32'h4, 32'h0, "no revert");
      gap(p[0]);
      gap(p[0]);
      chk(p[0] >= 1496 && p[0] <= 1626, 1'b1, "fallback rate");
      @(posedge pclk);
      run <= 1'b1;
      repeat (1200) @(negedge pclk);
      apb(1'b0, `PPGP_STAT_OFF, 32'h0);
      chk(rd & 32'h4, 32'h4, "edges resumed");
      $display("t_fail done");
   endtask : t_fail
   task t_off;
      @(posedge pclk);
      v2 <= 1'b0;
      repeat (50) @(negedge pclk);
      chk(drive.oe_a, 1'b1, "hysteresis");
      gap(p[0]);
      @(posedge pclk);
      v1 <= 1'b0;
      repeat (10) @(negedge pclk);
      chk(drive, 12'h000, "low supply");
      @(posedge pclk);
      v1 <= 1'b1;
      v2 <= 1'b1;
      gap(p[0]);
      gap(p[0]);
      @(posedge pclk);
      en_drv <= 1'b0;
      repeat (10) @(negedge pclk);
      chk(drive, 12'h000, "disabled");
      @(posedge pclk);
      en_drv <= 1'b1;
      repeat (10) @(negedge pclk);
      chk(drive.oe_a && drive.level < 8'h10, 1'b1, "ramp again");
      $display("t_off done");
   endtask : t_off
   initial
   begin
      pclk = 1'b0;
      forever
         #2 pclk = ~pclk;
   end
   // watchdog well past the expected run
   initial
   begin
      #240000;
      miscompares++;
      report_and_stop;
   end
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_float;
      t_start;
      t_ext;
      t_fail;
      t_off;
      report_and_stop;
   end
endmodule : push_pull_gate_phaser_tb
`default_nettype wire
